// file: design/sbrg_tick_gen.sv
// Modulo divider producing one tick every divisor_value bus clocks
`timescale 1ns/100ps
module sbrg_tick_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control side
    sbrg_tick_if.gen tif
);
    logic [12:0] cnt_ff;
    logic [12:0] nxt_cnt;
    logic tick_ff;
    logic run_ok;

    assign run_ok = tif.run && (tif.divisor_value != 13'h0000);
    assign tif.busy = run_ok;
    assign tif.tick = tick_ff;

    always_comb begin
        if (!run_ok || cnt_ff >= tif.divisor_value - 13'h0001) begin
            nxt_cnt = 13'h0000;
        end else begin
            nxt_cnt = cnt_ff + 13'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 13'h0000;
        end else if (run_ok) begin
            cnt_ff <= nxt_cnt;
        end else if (cnt_ff != 13'h0000) begin
            cnt_ff <= 13'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= run_ok && (cnt_ff >= tif.divisor_value - 13'h0001);
        end
    end

    property p_no_tick_idle;
        @(posedge pclk) disable iff (!presetn)
        !run_ok |=> !tick_ff;
    endproperty
    a_no_tick_idle: assert property (p_no_tick_idle)
        else $error("tick while generator stopped");

    property p_tick_spacing;
        @(posedge pclk) disable iff (!presetn)
        (tick_ff && run_ok && tif.divisor_value == 13'h0002
            && $stable(tif.divisor_value)) |=> !tick_ff;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("tick spacing wrong for divisor two");

    property p_div1_every;
        @(posedge pclk) disable iff (!presetn)
        (run_ok && tif.divisor_value == 13'h0001)[*2] |=> tick_ff;
    endproperty
    a_div1_every: assert property (p_div1_every)
        else $error("divisor one must tick every clock");
endmodule : sbrg_tick_gen

// file: design/sbrg_top.sv
// Baud rate generator with APB divisor registers
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
// Summary of operation
// - High divisor bits buffered, low write loads divisor
// - Divisor bits 12:8 high, 7:0 low
// - Zero divisor stops the generator
// - Low resets non-zero, idle until enable
// - Break interrupt when enabled and flag set
// - Edge interrupt when enabled and flag set
// - One rate shared by transmit and receive
module sbrg_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event flags from receiver logic
    input wire logic break_detect_flag,
    input wire logic rx_edge_flag,
    // Outputs
    output logic baud_tick,
    output logic break_irq,
    output logic edge_irq
);
    logic [7:0] high_buf_ff;
    logic [7:0] high_work_ff;
    logic [7:0] low_ff;
    logic [1:0] ctrl_ff;
    logic enabled_once_ff;
    logic [31:0] rdata_ff;
    logic wr_en;
    logic rd_en;
    logic [31:0] nxt_rdata;
    sbrg_tick_if tif ();

    function automatic logic addr_hit(input logic [11:0] a);
        return (a == sbrg_pkg::ADDR_DIV_HIGH) || (a == sbrg_pkg::ADDR_DIV_LOW)
            || (a == sbrg_pkg::ADDR_CTRL) || (a == sbrg_pkg::ADDR_STATUS);
    endfunction : addr_hit

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    // Unmapped addresses flag an error; writes to them are dropped
    assign pslverr = psel && penable && !addr_hit(paddr);
    assign prdata = rdata_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_buf_ff <= sbrg_pkg::RST_DIV_HIGH;
        end else if (wr_en && paddr == sbrg_pkg::ADDR_DIV_HIGH) begin
            high_buf_ff <= pwdata[7:0] & 8'hdf;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_work_ff <= sbrg_pkg::RST_DIV_HIGH;
            low_ff <= sbrg_pkg::RST_DIV_LOW;
        end else if (wr_en && paddr == sbrg_pkg::ADDR_DIV_LOW) begin
            high_work_ff <= high_buf_ff;
            low_ff <= pwdata[7:0];
        end else if (wr_en && paddr == sbrg_pkg::ADDR_DIV_HIGH) begin
            // Enable bits are not part of the divisor, so apply at once
            high_work_ff[7:6] <= pwdata[7:6];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= sbrg_pkg::RST_CTRL;
        end else if (wr_en && paddr == sbrg_pkg::ADDR_CTRL) begin
            ctrl_ff <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enabled_once_ff <= 1'b0;
        end else if (wr_en && paddr == sbrg_pkg::ADDR_CTRL
            && (pwdata[sbrg_pkg::BIT_RX_ON] || pwdata[sbrg_pkg::BIT_TX_ON]))
        begin
            enabled_once_ff <= 1'b1;
        end
    end

    assign tif.divisor_value = {
        high_work_ff[sbrg_pkg::HIGH_DIV_MSB:sbrg_pkg::HIGH_DIV_LSB], low_ff};
    assign tif.run = enabled_once_ff;

    sbrg_tick_gen u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .tif(tif)
    );

    assign baud_tick = tif.tick;

    assign break_irq = high_work_ff[sbrg_pkg::BIT_BRK_IE] && break_detect_flag;
    assign edge_irq = high_work_ff[sbrg_pkg::BIT_EDGE_IE] && rx_edge_flag;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (paddr)
            sbrg_pkg::ADDR_DIV_HIGH: nxt_rdata[7:0] = {high_work_ff[7:6],
                1'b0, high_buf_ff[4:0]};
            sbrg_pkg::ADDR_DIV_LOW: nxt_rdata[7:0] = low_ff;
            sbrg_pkg::ADDR_CTRL: nxt_rdata[1:0] = ctrl_ff;
            sbrg_pkg::ADDR_STATUS: nxt_rdata[2:0] = {tif.busy,
                rx_edge_flag, break_detect_flag};
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            rdata_ff <= nxt_rdata;
        end
    end

    property p_low_commits;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == sbrg_pkg::ADDR_DIV_LOW)
            |=> tif.divisor_value[12:8] == $past(high_buf_ff[4:0]);
    endproperty
    a_low_commits: assert property (p_low_commits)
        else $error("low write did not commit high buffer");

    property p_high_no_commit;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == sbrg_pkg::ADDR_DIV_HIGH)
            |=> $stable(tif.divisor_value);
    endproperty
    a_high_no_commit: assert property (p_high_no_commit)
        else $error("high write changed working divisor");

    property p_low_field;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == sbrg_pkg::ADDR_DIV_LOW)
            |=> tif.divisor_value[7:0] == $past(pwdata[7:0]);
    endproperty
    a_low_field: assert property (p_low_field)
        else $error("low divisor field misplaced");

    property p_idle_reset;
        @(posedge pclk) disable iff (!presetn)
        !enabled_once_ff |-> !baud_tick;
    endproperty
    a_idle_reset: assert property (p_idle_reset)
        else $error("generator ran before first enable");

    property p_break_irq;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == sbrg_pkg::ADDR_DIV_HIGH) |=> break_irq
            == ($past(pwdata[sbrg_pkg::BIT_BRK_IE]) && break_detect_flag);
    endproperty
    a_break_irq: assert property (p_break_irq)
        else $error("break interrupt mismatch");

    property p_edge_irq;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == sbrg_pkg::ADDR_DIV_HIGH) |=> edge_irq
            == ($past(pwdata[sbrg_pkg::BIT_EDGE_IE]) && rx_edge_flag);
    endproperty
    a_edge_irq: assert property (p_edge_irq)
        else $error("edge interrupt mismatch");

    property p_div_only_low;
        @(posedge pclk) disable iff (!presetn)
        !(wr_en && paddr == sbrg_pkg::ADDR_DIV_LOW)
            |=> $stable(tif.divisor_value);
    endproperty
    a_div_only_low: assert property (p_div_only_low)
        else $error("divisor moved without low write");

    property p_zero_stops;
        @(posedge pclk) disable iff (!presetn)
        (tif.divisor_value == 13'h0000) |=> !baud_tick;
    endproperty
    a_zero_stops: assert property (p_zero_stops)
        else $error("tick with zero divisor");

    property p_enable_arms;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == sbrg_pkg::ADDR_CTRL && pwdata[1:0] != 2'h0)
            |=> tif.run;
    endproperty
    a_enable_arms: assert property (p_enable_arms)
        else $error("enable write did not arm generator");

    property p_armed_stays;
        @(posedge pclk) disable iff (!presetn)
        tif.run |=> tif.run;
    endproperty
    a_armed_stays: assert property (p_armed_stays)
        else $error("generator disarmed without reset");

    property p_tick_single;
        @(posedge pclk) disable iff (!presetn)
        (baud_tick && tif.divisor_value > 13'h0001
            && $stable(tif.divisor_value)) |=> !baud_tick;
    endproperty
    a_tick_single: assert property (p_tick_single)
        else $error("tick wider than one cycle");

    property p_bad_addr;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && paddr > sbrg_pkg::ADDR_STATUS) |-> pslverr;
    endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("unmapped access without error");
endmodule : sbrg_top

// file: shared/sbrg_pkg.sv
// Package of register map and constants for the serial baud rate generator
package sbrg_pkg;
    localparam logic [11:0] ADDR_DIV_HIGH = 12'h000;
    localparam logic [11:0] ADDR_DIV_LOW = 12'h004;
    localparam logic [11:0] ADDR_CTRL = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    localparam int DIV_W = 13;
    localparam int HIGH_DIV_LSB = 0;
    localparam int HIGH_DIV_MSB = 4;
    localparam int BIT_BRK_IE = 7;
    localparam int BIT_EDGE_IE = 6;
    localparam int BIT_RX_ON = 0;
    localparam int BIT_TX_ON = 1;
    localparam int BIT_BRK_FLAG = 0;
    localparam int BIT_EDGE_FLAG = 1;
    localparam int BIT_GEN_RUN = 2;
    localparam logic [7:0] RST_DIV_HIGH = 8'h00;
    localparam logic [7:0] RST_DIV_LOW = 8'h04;
    localparam logic [1:0] RST_CTRL = 2'h0;
endpackage : sbrg_pkg

// file: shared/sbrg_tick_if.sv
// Interface carrying divisor and run control to the tick generator
`timescale 1ns/100ps
interface sbrg_tick_if;
    logic [12:0] divisor_value;
    logic run;
    logic tick;
    logic busy;
    modport ctl (output divisor_value, output run, input tick, input busy);
    modport gen (input divisor_value, input run, output tick, output busy);
endinterface : sbrg_tick_if

// file: verif/sbrg_flag_src.sv
// Stand-in for receiver logic that raises the event flags
`timescale 1ns/100ps
module sbrg_flag_src (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requested flag levels from the bench
    input wire logic [1:0] want,
    // Flags toward the block
    output logic break_detect_flag,
    output logic rx_edge_flag
);
    // Registered like real same-clock receiver flags, cleared on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_detect_flag <= 1'b0;
            rx_edge_flag <= 1'b0;
        end else begin
            break_detect_flag <= want[0];
            rx_edge_flag <= want[1];
        end
    end
endmodule : sbrg_flag_src

// file: verif/serial_baud_rate_generator_test.sv
// Self-checking bench for the baud rate generator
`timescale 1ns/100ps
module serial_baud_rate_generator_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, lf = 32'h51ef;
    logic pready, pslverr, baud_tick, break_irq, edge_irq, brk, edg;
    logic [1:0] want = 0;
    logic [12:0] d, old_d;
    logic [32:0] exp_q[$];
    int err_count = 0, n_compared = 0, gap = 0, last_gap = 0, nt = 0;
    int nt_mark = 0;
    always #12.5 pclk = ~pclk;
    sbrg_top sbrg_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .break_detect_flag(brk), .rx_edge_flag(edg), .baud_tick,
        .break_irq, .edge_irq);
    sbrg_flag_src sbrg_flag_src_inst (.pclk, .presetn, .want,
        .break_detect_flag(brk), .rx_edge_flag(edg));
    function automatic logic [31:0] lfsr(logic [31:0] l);
        return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
    endfunction : lfsr
    task automatic check(string what, logic [32:0] seen, logic [32:0] e);
        n_compared++;
        if (seen !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, seen);
        end
    endtask : check
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] v);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rd(logic [11:0] a, logic [32:0] e);
        exp_q.push_back(e);
        apb(0, a, 0);
    endtask : rd
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    // Read data and error flag checked as each read completes
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            check("read", {pslverr, prdata}, exp_q.pop_front());
        if (baud_tick === 1'b1) begin
            last_gap = gap;
            gap = 1;
            nt++;
        end else gap++;
    end
    initial begin
        #(25ns * 20000);
        err_count++;
        stop_test;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        check("pready", pready, 33'h1);
        rd(sbrg_pkg::ADDR_DIV_HIGH, 0);
        rd(sbrg_pkg::ADDR_DIV_LOW, 33'h4);
        rd(sbrg_pkg::ADDR_STATUS, 0);
        rd(12'h010, 33'h100000000);
        repeat (40) @(negedge pclk);
        check("idle ticks", nt, 0);
        apb(1, sbrg_pkg::ADDR_CTRL, 32'h2);
        rd(sbrg_pkg::ADDR_CTRL, 33'h2);
        rd(sbrg_pkg::ADDR_STATUS, 33'h4);
        repeat (30) @(negedge pclk);
        check("reset period", last_gap, 4);
        $display("test reset done");
        old_d = 4;
        for (int k = 0; k < 5; k++) begin
            lf = lfsr(lf);
            // Divisors one and two pin down the shortest periods
            d = (k == 0) ? {5'h01, lf[7:0]}
                : (k < 3) ? 13'(k) : 13'(lf[3:0]) + 13'h2;
            apb(1, sbrg_pkg::ADDR_DIV_HIGH, 32'(d[12:8]));
            apb(1, sbrg_pkg::ADDR_DIV_LOW, 32'(d[7:0]));
            // Lone high write must not move the working divisor
            apb(1, sbrg_pkg::ADDR_DIV_HIGH, 32'h1f);
            rd(sbrg_pkg::ADDR_DIV_HIGH, 33'h1f);
            rd(sbrg_pkg::ADDR_DIV_LOW, 33'(d[7:0]));
            repeat (3 * d + old_d + 20) @(negedge pclk);
            check("period", last_gap, 33'(d));
            old_d = d;
        end
        $display("test divisor done");
        // Zero divisor stops all ticks
        apb(1, sbrg_pkg::ADDR_DIV_HIGH, 0);
        apb(1, sbrg_pkg::ADDR_DIV_LOW, 0);
        repeat (old_d + 5) @(negedge pclk);
        nt_mark = nt;
        repeat (60) @(negedge pclk);
        check("zero divisor", nt, 33'(nt_mark));
        rd(sbrg_pkg::ADDR_STATUS, 33'h0);
        $display("test zero done");
        for (int i = 0; i < 16; i++) begin
            apb(1, sbrg_pkg::ADDR_DIV_HIGH, 32'(i[3:2]) << 6);
            want <= i[1:0];
            repeat (2) @(negedge pclk);
            check("break irq", break_irq, 33'(i[3] & i[0]));
            check("edge irq", edge_irq, 33'(i[2] & i[1]));
        end
        $display("test irq done");
        // Mid-run reset, then arm from the receive enable alone
        want <= 2'h0;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        last_gap = 0;
        nt_mark = nt;
        rd(sbrg_pkg::ADDR_DIV_LOW, 33'h4);
        rd(sbrg_pkg::ADDR_DIV_HIGH, 33'h0);
        repeat (40) @(negedge pclk);
        check("idle after reset", nt, 33'(nt_mark));
        apb(1, sbrg_pkg::ADDR_CTRL, 32'h1);
        rd(sbrg_pkg::ADDR_CTRL, 33'h1);
        rd(sbrg_pkg::ADDR_STATUS, 33'h4);
        repeat (30) @(negedge pclk);
        check("receive arms", last_gap, 4);
        $display("test reset again done");
        stop_test;
    end
endmodule : serial_baud_rate_generator_test
